/* File: core/cpu_flags_and_address_map.sv */
// CPU flags, program counter, vectors, stack and direct page mapping
// Function
// RULE1 - Half carry set from bit 3 carry or bit 4 no-borrow; cleared only by overflow clear. The code also clears it on add/sub without one.
// RULE2 - Software break sets break flag to tell it from a table call.
// RULE3 - Direct page flag 0 reaches 00H-0FFH, 1 reaches 100H-1FFH; set and clear ops.
// RULE4 - Overflow set on signed add/sub overflow; cleared only by overflow clear. The code also clears it on add/sub without overflow.
// RULE5 - Bit test copies memory bit 6 to overflow and bit 7 to negative.
// RULE6 - Negative flag follows sign bit of each data or arithmetic result. The code leaves it unchanged on a plain read.
// RULE7 - Program counter is 16 bits and wraps from FFFFH to 0000H.
// RULE8 - After reset start address is fetched from FFFEH and FFFFH.
// RULE9 - Table call vector n sits at 0FFC0H plus two bytes per step below 15.
// RULE10 - Page call is two bytes long and reaches the page call area.
// RULE11 - Interrupts jump through fixed vectors two bytes apart; external 1 at 0FFFCH.
// RULE12 - Unused vector locations behave as ordinary program memory.
// RULE13 - 192 byte user RAM; direct page chosen by RAM bank select at 00E1H.
// RULE14 - Direct page clear always selects RAM page 0 whatever bank select holds.
// RULE15 - Software executes direct page set after writing bank select.
// RULE16 - Stack index decrements after each save, increments before each restore.
// RULE17 - Subroutine exit restores PC only; interrupt exit restores PC and flags.
// RULE18 - Special function registers occupy data space 0B0H to 0FFH.
// RULE19 - Unimplemented special function addresses need no decode; reads are arbitrary.
// RULE20 - Serving an interrupt clears the global interrupt enable at once.
// RULE21 - Stack lives in 00H-0AFH; hardware leaves the stack index uninitialised.
// RULE22 - Interrupt entry pushes the flag word together with the program counter.
`timescale 1ns/1ns
`default_nettype none
`include "cpu_flags_consts.svh"

module cpu_flags_and_address_map (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	// Decoded operation, taken only while not busy
	input wire cpu_flags_pkg::op_req_s i_op,
	// Program memory, asynchronous read
	output var logic [15:0] o_pm_addr,
	input wire logic [7:0] i_pm_data,
	// Data memory and SFR window, asynchronous read
	output var cpu_flags_pkg::mem_req_s o_mem,
	input wire logic [7:0] i_dm_rdata,
	// Core state
	output var logic [15:0] o_pc,
	output var logic [7:0] o_psw,
	output var logic [7:0] o_sp,
	output var logic [7:0] o_ram_bank_select,
	output var logic [7:0] o_result,
	output var logic o_busy
);

	// ==========================================
	// State and registers
	typedef enum logic [2:0] {ST_IDLE, ST_VEC_LO, ST_VEC_HI, ST_PUSH, ST_POP, ST_RD} st_e;

	st_e state_q, state_d;
	logic [15:0] pc_q, pc_d;
	logic [7:0] psw_q, psw_d;
	logic [7:0] sp_q, sp_d;
	logic [7:0] bank_sel_q, bank_sel_d;
	logic [15:0] vec_q, vec_d;
	logic [23:0] sav_q, sav_d;
	logic [1:0] cnt_q, cnt_d;
	logic [1:0] last_q, last_d;
	logic to_vec_q, to_vec_d;
	logic interrupt_exit_instr_q, interrupt_exit_instr_d;
	logic bit_q, bit_d;
	logic rdrpr_q, rdrpr_d;
	logic [7:0] vlo_q, vlo_d;
	logic [7:0] res_q, res_d;
	logic [15:0] pm_addr_q;
	logic busy_q;
	cpu_flags_pkg::mem_req_s mem_q, mem_d;

	// ==========================================
	// Arithmetic; carry in is the carry flag, borrow is its inverse
	wire cin = psw_q[`PSW_C];
	wire [7:0] opa = i_op.a;
	wire [7:0] opb = i_op.b;
	wire [8:0] add_s = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
	wire [4:0] add_h = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
	wire [8:0] sub_s = {1'b0, opa} - {1'b0, opb} - {8'h00, ~cin};
	wire [4:0] sub_h = {1'b0, opa[3:0]} - {1'b0, opb[3:0]} - {4'h0, ~cin};
	wire add_v = (opa[7] == opb[7]) && (add_s[7] != opa[7]);
	wire sub_v = (opa[7] != opb[7]) && (sub_s[7] != opa[7]);

	// Direct page: bank select takes effect only while the page flag is set
	wire [7:0] page = psw_q[`PSW_G] ? bank_sel_q + 8'h01 : 8'h00; // RULE3 RULE13 RULE14
	wire [15:0] dir_addr = {page, opb};
	// Only the bank select is decoded; other SFR hits go to the port
	wire dir_sfr = (page == 8'h00) && (opb >= `SFR_LO); // RULE18 RULE19
	wire dir_bank = dir_sfr && (opb == `ADDR_BANK_SEL); // RULE13

	// Vector and call target selection
	wire [15:0] idx2 = {11'h000, i_op.idx, 1'b0};
	wire [15:0] tbl_vec = `VEC_TABLE0 - idx2; // RULE9
	wire [15:0] int_vec = `VEC_INT_TOP - idx2; // RULE11
	wire [15:0] pgcall_tgt = {`PAGE_CALL_HI, opb}; // RULE10

	// Return address past the calling instruction
	wire is_call = (i_op.op == cpu_flags_pkg::OP_CALL);
	wire is_pgcall = (i_op.op == cpu_flags_pkg::OP_PGCALL);
	wire is_int = (i_op.op == cpu_flags_pkg::OP_INT);
	wire [15:0] ret_len = is_call ? `LEN_CALL :
		is_pgcall ? `LEN_PGCALL :
		is_int ? `LEN_INT : `LEN_TABLE; // RULE10
	wire [15:0] ret_addr = pc_q + ret_len;

	// Stack byte order: PC high, PC low, flag word
	wire [1:0] push_nxt = cnt_q + 2'h1;
	wire [7:0] push_byte = (push_nxt == 2'h1) ? sav_q[15:8] : sav_q[7:0];
	wire [1:0] pop_j = interrupt_exit_instr_q ? cnt_q : cnt_q + 2'h1;
	wire [7:0] sp_inc = sp_q + 8'h01;
	wire [7:0] rd_data = rdrpr_q ? bank_sel_q : i_dm_rdata;

	// ==========================================
	// Sequencer and flag update
	always_comb begin
		state_d = state_q;
		pc_d = pc_q;
		psw_d = psw_q;
		sp_d = sp_q;
		bank_sel_d = bank_sel_q;
		vec_d = vec_q;
		sav_d = sav_q;
		cnt_d = cnt_q;
		last_d = last_q;
		to_vec_d = to_vec_q;
		interrupt_exit_instr_d = interrupt_exit_instr_q;
		bit_d = bit_q;
		rdrpr_d = rdrpr_q;
		vlo_d = vlo_q;
		res_d = res_q;
		mem_d = '0;
		case (state_q)
			ST_IDLE: begin
				case (i_op.op)
					cpu_flags_pkg::OP_STEP: begin
						pc_d = pc_q + {14'h0000, i_op.len}; // RULE7 RULE12
					end
					cpu_flags_pkg::OP_JMP: begin
						pc_d = i_op.target;
					end
					cpu_flags_pkg::OP_ADD: begin
						res_d = add_s[7:0];
						psw_d[`PSW_C] = add_s[8];
						psw_d[`PSW_H] = add_h[4]; // RULE1
						psw_d[`PSW_V] = add_v; // RULE4
						psw_d[`PSW_N] = add_s[7]; // RULE6
						psw_d[`PSW_Z] = (add_s[7:0] == 8'h00);
					end
					cpu_flags_pkg::OP_SUB: begin
						res_d = sub_s[7:0];
						psw_d[`PSW_C] = ~sub_s[8];
						psw_d[`PSW_H] = ~sub_h[4]; // RULE1
						psw_d[`PSW_V] = sub_v; // RULE4
						psw_d[`PSW_N] = sub_s[7]; // RULE6
						psw_d[`PSW_Z] = (sub_s[7:0] == 8'h00);
					end
					cpu_flags_pkg::OP_MOVE: begin
						res_d = opa;
						psw_d[`PSW_N] = opa[7]; // RULE6
						psw_d[`PSW_Z] = (opa == 8'h00);
					end
					cpu_flags_pkg::OP_OVCLR: begin
						psw_d[`PSW_V] = 1'b0; // RULE4
						psw_d[`PSW_H] = 1'b0; // RULE1
					end
					cpu_flags_pkg::OP_PAGE_SET: begin
						psw_d[`PSW_G] = 1'b1; // RULE3
					end
					cpu_flags_pkg::OP_PAGE_CLR: begin
						psw_d[`PSW_G] = 1'b0; // RULE3 RULE14
					end
					cpu_flags_pkg::OP_EI: begin
						psw_d[`PSW_I] = 1'b1;
					end
					cpu_flags_pkg::OP_DI: begin
						psw_d[`PSW_I] = 1'b0;
					end
					cpu_flags_pkg::OP_LDSP: begin
						sp_d = opa; // RULE21
					end
					cpu_flags_pkg::OP_RD, cpu_flags_pkg::OP_BIT: begin
						mem_d.addr = dir_addr;
						mem_d.re = 1'b1;
						mem_d.sfr = dir_sfr;
						rdrpr_d = dir_bank;
						bit_d = (i_op.op == cpu_flags_pkg::OP_BIT);
						state_d = ST_RD;
					end
					cpu_flags_pkg::OP_WR: begin
						mem_d.addr = dir_addr;
						mem_d.wdata = opa;
						mem_d.we = 1'b1;
						mem_d.sfr = dir_sfr;
						if (dir_bank) begin
							bank_sel_d = opa; // RULE13
						end
					end
					cpu_flags_pkg::OP_CALL, cpu_flags_pkg::OP_PGCALL, cpu_flags_pkg::OP_TBLCALL,
					cpu_flags_pkg::OP_BRK, cpu_flags_pkg::OP_INT: begin
						sav_d = {ret_addr, psw_q};
						cnt_d = 2'h0;
						last_d = `PUSH_LAST_CALL;
						to_vec_d = 1'b1;
						vec_d = tbl_vec;
						if (is_call) begin
							vec_d = i_op.target;
							to_vec_d = 1'b0;
						end else if (is_pgcall) begin
							vec_d = pgcall_tgt; // RULE10
							to_vec_d = 1'b0;
						end else if (i_op.op == cpu_flags_pkg::OP_BRK) begin
							vec_d = `VEC_TABLE0;
							last_d = `PUSH_LAST_INT;
							psw_d[`PSW_B] = 1'b1; // RULE2
							sav_d[`PSW_B] = 1'b1; // RULE2
						end else if (is_int) begin
							vec_d = int_vec; // RULE11
							last_d = `PUSH_LAST_INT; // RULE22
							psw_d[`PSW_B] = 1'b0;
							sav_d[`PSW_B] = 1'b0;
							psw_d[`PSW_I] = 1'b0; // RULE20
						end
						// First save, then step the index down
						mem_d.addr = {`STACK_PAGE, sp_q};
						mem_d.wdata = ret_addr[15:8];
						mem_d.we = 1'b1;
						sp_d = sp_q - 8'h01; // RULE16
						state_d = ST_PUSH;
					end
					cpu_flags_pkg::OP_RET, cpu_flags_pkg::OP_INTERRUPT_EXIT_INSTR: begin
						interrupt_exit_instr_d = (i_op.op == cpu_flags_pkg::OP_INTERRUPT_EXIT_INSTR); // RULE17
						cnt_d = 2'h0;
						sp_d = sp_inc; // RULE16
						mem_d.addr = {`STACK_PAGE, sp_inc};
						mem_d.re = 1'b1;
						state_d = ST_POP;
					end
					default: begin
					end
				endcase
			end
			ST_PUSH: begin
				if (cnt_q == last_q) begin
					if (to_vec_q) begin
						state_d = ST_VEC_LO;
					end else begin
						pc_d = vec_q;
						state_d = ST_IDLE;
					end
				end else begin
					cnt_d = push_nxt;
					mem_d.addr = {`STACK_PAGE, sp_q};
					mem_d.wdata = push_byte; // RULE22
					mem_d.we = 1'b1;
					sp_d = sp_q - 8'h01; // RULE16
				end
			end
			ST_POP: begin
				// Restore order is the reverse of the save order
				if (pop_j == 2'h0) begin
					psw_d = i_dm_rdata; // RULE17
				end else if (pop_j == 2'h1) begin
					sav_d[15:8] = i_dm_rdata;
				end
				if (pop_j == 2'h2) begin
					pc_d = {i_dm_rdata, sav_q[15:8]}; // RULE17
					state_d = ST_IDLE;
				end else begin
					cnt_d = cnt_q + 2'h1;
					sp_d = sp_inc; // RULE16
					mem_d.addr = {`STACK_PAGE, sp_inc};
					mem_d.re = 1'b1;
				end
			end
			ST_RD: begin
				res_d = rd_data;
				if (bit_q) begin
					psw_d[`PSW_V] = rd_data[6]; // RULE5
					psw_d[`PSW_N] = rd_data[7]; // RULE5
				end
				state_d = ST_IDLE;
			end
			ST_VEC_LO: begin
				vlo_d = i_pm_data;
				state_d = ST_VEC_HI;
			end
			ST_VEC_HI: begin
				pc_d = {i_pm_data, vlo_q}; // RULE8 RULE9 RULE11
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// Fetch address follows the vector walk, else the next PC
	wire [15:0] pm_addr_d = (state_d == ST_VEC_LO) ? vec_d :
		(state_d == ST_VEC_HI) ? vec_q + 16'h0001 : pc_d; // RULE8

	// ==========================================
	// Control registers; reset walks into the reset vector fetch
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			state_q <= ST_VEC_LO;
			vec_q <= `VEC_RESET; // RULE8
			pm_addr_q <= `VEC_RESET; // RULE8
			pc_q <= 16'h0000;
			psw_q <= `PSW_RST;
			bank_sel_q <= `BANK_SEL_RST;
			busy_q <= 1'b1;
			mem_q <= '0;
		end else begin
			state_q <= state_d;
			vec_q <= vec_d;
			pm_addr_q <= pm_addr_d;
			pc_q <= pc_d;
			psw_q <= psw_d;
			bank_sel_q <= bank_sel_d;
			busy_q <= (state_d != ST_IDLE);
			mem_q <= mem_d;
		end
	end

	// Sequence bookkeeping
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_b) begin
			sav_q <= 24'h000000;
			cnt_q <= 2'h0;
			last_q <= 2'h0;
			to_vec_q <= 1'b0;
			interrupt_exit_instr_q <= 1'b0;
			bit_q <= 1'b0;
			rdrpr_q <= 1'b0;
			vlo_q <= 8'h00;
			res_q <= 8'h00;
		end else begin
			sav_q <= sav_d;
			cnt_q <= cnt_d;
			last_q <= last_d;
			to_vec_q <= to_vec_d;
			interrupt_exit_instr_q <= interrupt_exit_instr_d;
			bit_q <= bit_d;
			rdrpr_q <= rdrpr_d;
			vlo_q <= vlo_d;
			res_q <= res_d;
		end
	end

	// Stack index has no reset; software must load it first
	always_ff @(posedge i_clk_sys) begin
		sp_q <= sp_d; // RULE21
	end

	// ==========================================
	// Outputs, all from flops
	assign o_pm_addr = pm_addr_q;
	assign o_mem = mem_q;
	assign o_pc = pc_q;
	assign o_psw = psw_q;
	assign o_sp = sp_q;
	assign o_ram_bank_select = bank_sel_q;
	assign o_result = res_q;
	assign o_busy = busy_q;

endmodule

`default_nettype wire

/* File: core/cpu_flags_consts.svh */
// Constants for the CPU flag and address map block
`ifndef CPU_FLAGS_CONSTS_SVH
`define CPU_FLAGS_CONSTS_SVH

// ==========================================
// Flag word bit positions
`define PSW_C 0
`define PSW_Z 1
`define PSW_I 2
`define PSW_H 3
`define PSW_B 4
`define PSW_G 5
`define PSW_V 6
`define PSW_N 7
`define PSW_RST 8'h00

// ==========================================
// Program memory vectors
`define VEC_RESET 16'hfffe
`define VEC_TABLE0 16'hffde
`define VEC_INT_TOP 16'hfffc
`define PAGE_CALL_HI 8'hff

// ==========================================
// Instruction lengths for return addresses
`define LEN_CALL 16'h0003
`define LEN_PGCALL 16'h0002
`define LEN_TABLE 16'h0001
`define LEN_INT 16'h0000

// ==========================================
// Data space map
`define SFR_LO 8'hb0
`define ADDR_BANK_SEL 8'he1
`define BANK_SEL_RST 8'h00
`define STACK_PAGE 8'h00
`define PUSH_LAST_CALL 2'h1
`define PUSH_LAST_INT 2'h2

`endif

/* File: core/cpu_flags_pkg.sv */
// Types shared by the CPU flag and address map block
package cpu_flags_pkg;

	// ==========================================
	// Decoded operations from the sequencer
	typedef enum logic [4:0] {
		OP_NONE, OP_STEP, OP_JMP, OP_ADD, OP_SUB, OP_MOVE,
		OP_RD, OP_WR, OP_BIT, OP_OVCLR, OP_PAGE_SET, OP_PAGE_CLR,
		OP_EI, OP_DI, OP_LDSP, OP_CALL, OP_PGCALL, OP_TBLCALL,
		OP_BRK, OP_INT, OP_RET, OP_INTERRUPT_EXIT_INSTR
	} op_e;

	// ==========================================
	// Operation request
	typedef struct packed {
		op_e op;
		logic [7:0] a;
		logic [7:0] b;
		logic [15:0] target;
		logic [3:0] idx;
		logic [1:0] len;
	} op_req_s;

	// ==========================================
	// Data memory request
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic we;
		logic re;
		logic sfr;
	} mem_req_s;

endpackage

/* File: tb/cpu_flags_mem_model.sv */
// Program ROM and data RAM standing beside the core
`timescale 1ns/1ns
`default_nettype none
module cpu_flags_mem_model (
	// Clock
	input wire logic i_clk_sys,
	// Program memory
	input wire logic [15:0] i_pm_addr,
	output logic [7:0] o_pm_data,
	// Data memory
	input wire cpu_flags_pkg::mem_req_s i_mem,
	output logic [7:0] o_dm_rdata
);
	// ==========================================
	// Storage
	logic [7:0] mem [0:511];
	// ROM byte mixes address halves, so vectors are easy to predict
	assign o_pm_data = i_pm_addr[7:0] ^ i_pm_addr[15:8];
	// Idle bus shows inverted data, never a helpful stale value
	assign o_dm_rdata = i_mem.re ? mem[i_mem.addr[8:0]] : ~mem[i_mem.addr[8:0]];
	// Writes land on the clock edge
	always @(posedge i_clk_sys) begin
		if (i_mem.we) mem[i_mem.addr[8:0]] <= i_mem.wdata;
	end
endmodule
`default_nettype wire

/* File: tb/cpu_flags_sva.sv */
// Checker for flag, vector and page behaviour at the core ports
`timescale 1ns/1ns
`default_nettype none
module cpu_flags_sva (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst_b,
	// Operation and memories
	input wire cpu_flags_pkg::op_req_s i_op,
	input wire logic [15:0] o_pm_addr,
	input wire logic [7:0] i_pm_data,
	input wire cpu_flags_pkg::mem_req_s o_mem,
	input wire logic [7:0] i_dm_rdata,
	// Core state
	input wire logic [15:0] o_pc,
	input wire logic [7:0] o_psw,
	input wire logic [7:0] o_sp,
	input wire logic [7:0] o_ram_bank_select,
	input wire logic [7:0] o_result,
	input wire logic o_busy
);
	// ==========================================
	// Operation taken at this edge
	wire cpu_flags_pkg::op_e op = o_busy ? cpu_flags_pkg::OP_NONE : i_op.op;
	logic [15:0] vec_q;
	// Vector latched at entry, since idx may change while busy
	always_ff @(posedge i_clk_sys) begin
		if (op == cpu_flags_pkg::OP_INT) vec_q <= 16'hfffc - {11'h0, i_op.idx, 1'b0};
	end
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_b);
	a_start_fetch: assert property (disable iff (1'b0) !i_rst_b ##1 i_rst_b |->
		o_pm_addr == 16'hfffe ##1 o_pm_addr == 16'hffff) else $error("bad start fetch");
	a_pc_wrap: assert property (op == cpu_flags_pkg::OP_STEP && i_op.len == 2'h1 &&
		o_pc == 16'hffff |=> o_pc == 16'h0000) else $error("pc did not wrap");
	a_bit_copy: assert property (op == cpu_flags_pkg::OP_BIT ##1 1'b1 |=>
		o_psw[7:6] == $past(i_dm_rdata[7:6])) else $error("bit test flags wrong");
	a_ovf_clear: assert property (op == cpu_flags_pkg::OP_OVCLR |=>
		!o_psw[6] && !o_psw[3]) else $error("overflow clear failed");
	a_page_set: assert property (op == cpu_flags_pkg::OP_PAGE_SET |=> o_psw[5])
		else $error("page flag not set");
	a_page_low: assert property (!o_psw[5] && $past(op == cpu_flags_pkg::OP_WR) |->
		o_mem.addr[15:8] == 8'h00) else $error("page not zero");
	a_page_high: assert property (o_psw[5] && $past(op == cpu_flags_pkg::OP_WR) |->
		o_mem.addr[15:8] == o_ram_bank_select + 8'h01) else $error("page wrong");
	a_sfr_window: assert property (o_mem.we || o_mem.re |-> o_mem.sfr ==
		(o_mem.addr[15:8] == 8'h00 && o_mem.addr[7:0] >= 8'hb0)) else $error("sfr flag wrong");
	a_int_masks: assert property (op == cpu_flags_pkg::OP_INT |=> !o_psw[2])
		else $error("enable not cleared");
	a_call_sp: assert property (op == cpu_flags_pkg::OP_CALL |=> o_sp == $past(o_sp) - 8'h01
		##1 o_sp == $past(o_sp, 2) - 8'h02) else $error("stack index order wrong");
	a_int_vector: assert property (op == cpu_flags_pkg::OP_INT |-> ##[2:6]
		o_pm_addr == vec_q) else $error("interrupt vector wrong");
	c_int: cover property (op == cpu_flags_pkg::OP_INT);
	c_call: cover property (op == cpu_flags_pkg::OP_CALL);
	c_bit: cover property (op == cpu_flags_pkg::OP_BIT);
endmodule
bind cpu_flags_and_address_map cpu_flags_sva i_cpu_flags_sva (.i_clk_sys, .i_rst_b, .i_op,
	.o_pm_addr, .i_pm_data, .o_mem, .i_dm_rdata, .o_pc, .o_psw, .o_sp, .o_ram_bank_select,
	.o_result, .o_busy);
`default_nettype wire

/* File: tb/tb_cpu_flags_and_address_map.sv */
// Self-checking bench for the flag and address map core
`timescale 1ns/1ns
`default_nettype none
module tb_cpu_flags_and_address_map;
	// ==========================================
	// Signals
	logic i_clk_sys = 1'b0;
	logic i_rst_b = 1'b0;
	cpu_flags_pkg::op_req_s op_r = '0;
	cpu_flags_pkg::mem_req_s mem;
	logic [15:0] pm_addr, pc;
	logic [7:0] pm_data, dm_rdata, cpu_flag_word, sp, bank, result;
	logic busy;
	int n_errors = 0;
	int total_checks = 0;
	cpu_flags_and_address_map i_cpu_flags_and_address_map (.i_clk_sys(i_clk_sys),
		.i_rst_b(i_rst_b), .i_op(op_r), .o_pm_addr(pm_addr), .i_pm_data(pm_data), .o_mem(mem),
		.i_dm_rdata(dm_rdata), .o_pc(pc), .o_psw(cpu_flag_word), .o_sp(sp), .o_ram_bank_select(bank),
		.o_result(result), .o_busy(busy));
	cpu_flags_mem_model i_cpu_flags_mem_model (.i_clk_sys(i_clk_sys), .i_pm_addr(pm_addr),
		.o_pm_data(pm_data), .i_mem(mem), .o_dm_rdata(dm_rdata));
	// 50 MHz clock
	initial forever #10 i_clk_sys = ~i_clk_sys;
	// ==========================================
	// Tasks
	task finish_test;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// Bounded wait, a hang ends the run
	task automatic wait_idle;
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 20) begin
			@(negedge i_clk_sys);
			n++;
		end
		if (busy !== 1'b0) begin
			n_errors++;
			finish_test();
		end
	endtask
	// One operation for one edge, then idle until done
	task automatic do_op(input cpu_flags_pkg::op_e k, input logic [7:0] a, input logic [7:0] b,
		input logic [15:0] t);
		@(negedge i_clk_sys);
		op_r = '{k, a, b, t, b[3:0], 2'h1};
		@(negedge i_clk_sys);
		op_r.op = cpu_flags_pkg::OP_NONE;
		wait_idle();
	endtask
	// ==========================================
	// Main sequence
	initial begin
		repeat (6) @(negedge i_clk_sys);
		i_rst_b = 1'b1;
		wait_idle();
		chk(pc, 16'h0001);
		chk({cpu_flag_word, bank}, 16'h0000);
		$display("test reset done");
		do_op(cpu_flags_pkg::OP_LDSP, 8'haf, 8'h00, 16'h0);
		do_op(cpu_flags_pkg::OP_ADD, 8'h0f, 8'h01, 16'h0);
		chk({result, cpu_flag_word[7], cpu_flag_word[3]}, 16'h0041);
		do_op(cpu_flags_pkg::OP_ADD, 8'h7f, 8'h01, 16'h0);
		chk({result, cpu_flag_word[7:6], cpu_flag_word[3]}, 16'h0407);
		do_op(cpu_flags_pkg::OP_SUB, 8'h7f, 8'hfe, 16'h0);
		chk({result, cpu_flag_word[7:6], cpu_flag_word[3], cpu_flag_word[0]}, 16'h080e);
		do_op(cpu_flags_pkg::OP_OVCLR, 8'h00, 8'h00, 16'h0);
		chk({cpu_flag_word[6], cpu_flag_word[3]}, 16'h0000);
		do_op(cpu_flags_pkg::OP_MOVE, 8'h00, 8'h00, 16'h0);
		chk({result, cpu_flag_word[7], cpu_flag_word[1]}, 16'h0001);
		$display("test flags done");
		do_op(cpu_flags_pkg::OP_PAGE_SET, 8'h00, 8'h00, 16'h0);
		do_op(cpu_flags_pkg::OP_WR, 8'h55, 8'h10, 16'h0);
		chk(mem.addr, 16'h0110);
		do_op(cpu_flags_pkg::OP_PAGE_CLR, 8'h00, 8'h00, 16'h0);
		do_op(cpu_flags_pkg::OP_WR, 8'h03, 8'he1, 16'h0);
		chk({bank, 7'h0, mem.sfr}, 16'h0301);
		do_op(cpu_flags_pkg::OP_RD, 8'h00, 8'he1, 16'h0);
		chk(result, 16'h0003);
		do_op(cpu_flags_pkg::OP_PAGE_SET, 8'h00, 8'h00, 16'h0);
		do_op(cpu_flags_pkg::OP_WR, 8'h5a, 8'h20, 16'h0);
		chk(mem.addr, 16'h0420);
		do_op(cpu_flags_pkg::OP_PAGE_CLR, 8'h00, 8'h00, 16'h0);
		do_op(cpu_flags_pkg::OP_WR, 8'hc0, 8'h30, 16'h0);
		chk(mem.addr, 16'h0030);
		do_op(cpu_flags_pkg::OP_BIT, 8'h00, 8'h30, 16'h0);
		chk({result, cpu_flag_word[7:6]}, 16'h0303);
		$display("test pages done");
		do_op(cpu_flags_pkg::OP_CALL, 8'h00, 8'h00, 16'h0100);
		chk({pc, sp}, {16'h0100, 8'had});
		chk({i_cpu_flags_mem_model.mem[9'haf], i_cpu_flags_mem_model.mem[9'hae]}, 16'h0004);
		do_op(cpu_flags_pkg::OP_RET, 8'h00, 8'h00, 16'h0);
		chk({pc, sp}, {16'h0004, 8'haf});
		do_op(cpu_flags_pkg::OP_PGCALL, 8'h00, 8'h35, 16'h0);
		chk(pc, 16'hff35);
		chk(i_cpu_flags_mem_model.mem[9'hae], 16'h0006);
		do_op(cpu_flags_pkg::OP_RET, 8'h00, 8'h00, 16'h0);
		do_op(cpu_flags_pkg::OP_TBLCALL, 8'h00, 8'h0f, 16'h0);
		chk(pc, 16'h3e3f);
		do_op(cpu_flags_pkg::OP_RET, 8'h00, 8'h00, 16'h0);
		chk(pc, 16'h0007);
		$display("test calls done");
		do_op(cpu_flags_pkg::OP_EI, 8'h00, 8'h00, 16'h0);
		do_op(cpu_flags_pkg::OP_INT, 8'h00, 8'h00, 16'h0);
		chk({pc, sp}, {16'h0203, 8'hac});
		chk({cpu_flag_word[2], i_cpu_flags_mem_model.mem[9'had][2], i_cpu_flags_mem_model.mem[9'had][4]},
			16'h0002);
		do_op(cpu_flags_pkg::OP_INTERRUPT_EXIT_INSTR, 8'h00, 8'h00, 16'h0);
		chk({pc, sp, 7'h0, cpu_flag_word[2]}, {16'h0007, 8'haf, 8'h01});
		do_op(cpu_flags_pkg::OP_BRK, 8'h00, 8'h00, 16'h0);
		chk({pc, 7'h0, cpu_flag_word[4]}, {16'h2021, 8'h01});
		$display("test interrupts done");
		do_op(cpu_flags_pkg::OP_JMP, 8'h00, 8'h00, 16'hffff);
		do_op(cpu_flags_pkg::OP_STEP, 8'h00, 8'h00, 16'h0);
		chk(pc, 16'h0000);
		$display("test wrap done");
		finish_test();
	end
endmodule
`default_nettype wire
